// >>> fault_log_i2c_access_test.sv
/* Self-checking bench: host and device ends of the fault log access block over flac_if.
   Assumes the design files, flac_monitor and flac_defines.svh in one folder. */
`include "flac_defines.svh"
module fault_log_i2c_access_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rd_ready = 1'b1, rec_req = 1'b0;
   logic rec_to_array = 1'b0, user_tag_mode = 1'b0, reconfig_req = 1'b0;
   logic [7:0] cmd_opc = 8'h00;
   logic [1:0] cmd_nargs = 2'h0;
   logic [15:0] cmd_args = 16'h0000;
   logic [6:0] cmd_nread = 7'h00;
   logic [55:0] rec_data = 56'h0;
   logic cmd_ready, rd_valid, done, reconfig_ack, reconfig_rej, log_full, prog_mode;
   logic [7:0] rd_data;
   logic [3:0] next_row;
   logic [7:0] q[$];
   logic done_seen;
   int cyc;
   int err_total = 0;
   int compares = 0;
   flac_if flac_if_inst();
   flac_device flac_device_inst
   (
      .clk(clk), .rst(rst), .lnk(flac_if_inst), .rec_req(rec_req), .rec_to_array(rec_to_array),
      .rec_data(rec_data), .user_tag_mode(user_tag_mode), .reconfig_req(reconfig_req),
      .reconfig_ack(reconfig_ack), .reconfig_rej(reconfig_rej), .next_row(next_row),
      .log_full(log_full), .prog_mode(prog_mode)
   );
   flac_host flac_host_inst
   (
      .clk(clk), .rst(rst), .lnk(flac_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_opc(cmd_opc), .cmd_nargs(cmd_nargs), .cmd_args(cmd_args), .cmd_nread(cmd_nread),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .done(done)
   );
   flac_monitor flac_monitor_inst
   (
      .clk(clk), .rst(rst), .h_valid(flac_if_inst.h_valid), .h_ready(flac_if_inst.h_ready),
      .h_data(flac_if_inst.h_data), .h_start(flac_if_inst.h_start),
      .h_read(flac_if_inst.h_read), .h_stop(flac_if_inst.h_stop),
      .d_valid(flac_if_inst.d_valid), .d_ready(flac_if_inst.d_ready),
      .d_data(flac_if_inst.d_data), .h_nack(flac_if_inst.h_nack)
   );
   initial
      forever #2 clk = ~clk;
   // *************
   // Shared tasks
   // *************
   task automatic report_and_stop;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [55:0] got, input logic [55:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [7:0] pat(input int row, input int k);
      return 8'ha0 + 8'(row * 8 + k);
   endfunction : pat
   task automatic reset_dut;
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : reset_dut
   // Issues one command and gathers read bytes until done and the FIFO is empty
   task automatic run(input logic [7:0] opc, input logic [1:0] na, input logic [15:0] arg,
      input logic [6:0] nr, input int hold, input int lim);
      logic sent;
      sent = 1'b0;
      done_seen = 1'b0;
      q.delete();
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_opc <= opc;
      cmd_nargs <= na;
      cmd_args <= arg;
      cmd_nread <= nr;
      for (cyc = 0; cyc < lim; cyc++)
      begin
         @(negedge clk);
         if (rd_valid === 1'b1 && rd_ready === 1'b1)
            q.push_back(rd_data);
         if (done === 1'b1)
            done_seen = 1'b1;
         if (done_seen && rd_valid !== 1'b1)
            break;
         if (cmd_ready === 1'b1)
            sent = 1'b1;
         @(posedge clk);
         if (sent)
            cmd_valid <= 1'b0;
         rd_ready <= (cyc >= hold);
      end
   endtask : run
   task automatic cmp_row(input int base, input int row);
      for (int k = 0; k < 7; k++)
         check(56'(q[base + k]), 56'(pat(row, k)));
   endtask : cmp_row
   task automatic unlock(input logic [7:0] key);
      run(`FLAC_OP_UNLOCK, 2'h1, {key, 8'h00}, 7'h01, 0, 200);
      check(56'(q.size()), 56'h1);
   endtask : unlock
   task automatic grant;
      unlock(`FLAC_UNLOCK_KEY);
      for (int n = 0; n < 40 && q[0] !== `FLAC_STAT_GRANTED; n++)
         unlock(`FLAC_UNLOCK_KEY);
      check(56'(q[0]), 56'(`FLAC_STAT_GRANTED));
   endtask : grant
   task automatic record(input logic arr, input int row, input int w);
      logic [55:0] d;
      for (int k = 0; k < 7; k++)
         d[k * 8 +: 8] = pat(row, k);
      @(posedge clk);
      rec_req <= 1'b1;
      rec_to_array <= arr;
      rec_data <= d;
      @(posedge clk);
      rec_req <= 1'b0;
      repeat (w) @(posedge clk);
   endtask : record
   task automatic reconf(input logic [1:0] exp);
      logic [1:0] seen;
      seen = 2'b00;
      @(posedge clk);
      reconfig_req <= 1'b1;
      @(posedge clk);
      reconfig_req <= 1'b0;
      repeat (3)
      begin
         @(negedge clk);
         seen = seen | {reconfig_ack, reconfig_rej};
      end
      check(56'(seen), 56'(exp));
   endtask : reconf
   task automatic utm(input logic v);
      @(posedge clk);
      user_tag_mode <= v;
      repeat (4) @(posedge clk);
   endtask : utm
   // *********
   // Scenarios
   // *********
   task automatic t_locked;
      check(56'({next_row, log_full, prog_mode}), 56'h0);
      unlock(8'h55);
      check(56'(q[0]), 56'(`FLAC_STAT_GNT_BITS));
      run(`FLAC_OP_ERASE, 2'h0, 16'h0000, 7'h00, 0, 400);
      check(56'({done_seen, flac_if_inst.h_ready}), 56'h3);
      run(`FLAC_OP_READ_VOL, 2'h0, 16'h0000, 7'h07, 0, 100);
      check(56'({done_seen, q.size()}), 56'h0);
      reset_dut();
   endtask : t_locked
   task automatic t_record;
      for (int r = 0; r < 3; r++)
         record(1'b1, r, 30);
      check(56'(next_row), 56'h3);
      record(1'b0, 7, 30);
      check(56'(next_row), 56'h3);
      record(1'b1, 3, 0);
      reconf(2'b01);
      repeat (30) @(posedge clk);
      reconf(2'b10);
   endtask : t_record
   task automatic t_unlocked;
      logic [3:0] r;
      grant();
      r = next_row;
      record(1'b1, 9, 30);
      check(56'(next_row), 56'(r));
      run(`FLAC_OP_READ_VOL, 2'h0, 16'h0000, 7'h07, 0, 300);
      cmp_row(0, 7);
      run(`FLAC_OP_READ_REC, 2'h1, 16'h1000, 7'h0e, 0, 300);
      cmp_row(0, 1);
      cmp_row(7, 2);
      run(`FLAC_OP_READ_ALL, 2'h0, 16'h0000, 7'h70, 200, 3000);
      check(56'(q.size()), 56'h70);
      for (int n = 0; n < 4; n++)
         cmp_row(n * 7, n);
   endtask : t_unlocked
   task automatic t_erase;
      run(`FLAC_OP_PROG, 2'h2, `FLAC_PROG_KEY, 7'h00, 0, 200);
      check(56'(prog_mode), 56'h1);
      run(`FLAC_OP_ERASE, 2'h0, 16'h0000, 7'h00, 0, 1000);
      // The host is done at once; the link stays held off for the erase time
      repeat (`FLAC_ERASE_CYCLES - 4) @(negedge clk);
      check(56'({done_seen, flac_if_inst.h_ready}), 56'h2);
      repeat (8) @(negedge clk);
      check(56'(flac_if_inst.h_ready), 56'h1);
      grant();
      run(`FLAC_OP_READ_REC, 2'h1, 16'h0000, 7'h07, 0, 300);
      check(56'(q[0] === pat(0, 0)), 56'h0);
      run(`FLAC_OP_USER, 2'h0, 16'h0000, 7'h00, 0, 200);
   endtask : t_erase
   task automatic t_relock;
      logic [3:0] r;
      unlock(8'h00);
      check(56'(q[0][7:6]), 56'h0);
      r = next_row;
      record(1'b1, 4, 30);
      check(56'(next_row), 56'(r + 4'h1));
      // Fill the remaining rows: the row number wraps and the log reads full
      repeat (15 - r)
         record(1'b1, 5, 12);
      check(56'({next_row, log_full}), 56'h1);
   endtask : t_relock
   task automatic t_user;
      logic [3:0] r;
      utm(1'b1);
      r = next_row;
      record(1'b1, 5, 30);
      check(56'(next_row), 56'(r));
      utm(1'b0);
      grant();
      utm(1'b1);
      run(`FLAC_OP_READ_ALL, 2'h0, 16'h0000, 7'h07, 0, 100);
      check(56'(q.size()), 56'h0);
      utm(1'b0);
      reset_dut();
   endtask : t_user
   initial
   begin
      #200000;
      err_total++;
      report_and_stop();
   end
   initial
   begin
      reset_dut();
      t_locked();
      t_record();
      t_unlocked();
      t_erase();
      t_relock();
      t_user();
      report_and_stop();
   end
endmodule : fault_log_i2c_access_test

// >>> flac_defines.svh
/*
 * Holds the opcodes, key values, status encodings and timing counts of the fault log access block.
 * Assumes it is included by its bare name from every file that needs a constant.
 */
`ifndef FLAC_DEFINES_SVH
`define FLAC_DEFINES_SVH
`define FLAC_ROWS 5'h10
`define FLAC_REC_BYTES 3'h7
`define FLAC_OP_ERASE 8'h71
`define FLAC_OP_READ_VOL 8'h73
`define FLAC_OP_UNLOCK 8'h74
`define FLAC_OP_READ_REC 8'h75
`define FLAC_OP_READ_ALL 8'h76
`define FLAC_OP_PROG 8'h04
`define FLAC_OP_USER 8'h05
`define FLAC_UNLOCK_KEY 8'hac
`define FLAC_PROG_KEY 16'he53d
`define FLAC_STAT_RECORDING 8'h00
`define FLAC_STAT_GRANTED 8'hf0
`define FLAC_STAT_REQ_BITS 8'hc0
`define FLAC_STAT_GNT_BITS 8'h30
`define FLAC_ERASE_TIME_NS 400
`define FLAC_CLK_PERIOD_NS 4
`define FLAC_ERASE_CYCLES ((`FLAC_ERASE_TIME_NS + `FLAC_CLK_PERIOD_NS - 1) / `FLAC_CLK_PERIOD_NS)
`define FLAC_PROG_TIME_NS 40
`define FLAC_PROG_CYCLES ((`FLAC_PROG_TIME_NS + `FLAC_CLK_PERIOD_NS - 1) / `FLAC_CLK_PERIOD_NS)
`define FLAC_FIFO_DEPTH 16
`endif

// >>> flac_device.sv
/*
 * Holds the device end: command decode, unlock, erase and readout of the fault log store.
 * Assumes byte framing on the flac_if link and a controller link pulse that asks for a record.
 */
`include "flac_defines.svh"
module flac_device
import flac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   flac_if.dev lnk,
   input wire logic rec_req,
   input wire logic rec_to_array,
   input wire logic [55:0] rec_data,
   input wire logic user_tag_mode,
   input wire logic reconfig_req,
   output logic reconfig_ack,
   output logic reconfig_rej,
   output logic [3:0] next_row,
   output logic log_full,
   output logic prog_mode
);
   typedef struct packed
   {
      flac_dev_e st;
      logic [7:0] opc;
      logic [7:0] arg0;
      logic [1:0] argn;
      logic unlocked;
      logic granted;
      logic prog;
      logic [3:0] row;
      logic full;
      logic [3:0] rd_row;
      logic [2:0] rd_byte;
      logic rd_vol;
      logic [7:0] tx;
      logic tx_v;
      logic rsp_stat;
      logic [15:0] nv_cnt;
      logic nv_erase;
      logic ut_q1;
      logic ut_q2;
      logic rc_ack;
      logic rc_rej;
   } flac_dev_s;
   flac_dev_s s_q, s_d;
   logic [55:0] arr [16];
   logic [55:0] vol_q;
   logic wr_arr, busy, last;
   function automatic logic [7:0] pick(input logic [55:0] rec, input logic [2:0] idx);
      pick = rec[8*idx +: 8];
   endfunction : pick
   // Host bytes are held off while an erase runs
   assign busy = (s_q.nv_cnt != '0);
   assign lnk.h_ready = (s_q.st != FLAC_BUSY);
   assign lnk.d_valid = s_q.tx_v;
   assign lnk.d_data = s_q.tx;
   assign next_row = s_q.row;
   assign log_full = s_q.full;
   assign prog_mode = s_q.prog;
   assign reconfig_ack = s_q.rc_ack;
   assign reconfig_rej = s_q.rc_rej;
   assign last = (s_q.rd_byte == `FLAC_REC_BYTES - 3'h1);
   // Recording is blocked while unlocked or in user tag mode
   assign wr_arr = rec_req && !s_q.unlocked && !s_q.ut_q2 && !busy;
   always_comb
   begin
      s_d = s_q;
      s_d.ut_q1 = user_tag_mode;
      s_d.ut_q2 = s_q.ut_q1;
      s_d.rc_ack = 1'b0;
      s_d.rc_rej = 1'b0;
      if (busy)
      begin
         s_d.nv_cnt = s_q.nv_cnt - 16'h1;
      end
      if (s_d.nv_cnt == '0 && s_q.nv_erase)
      begin
         s_d.nv_erase = 1'b0;
      end
      // ****************************
      // Recording and reconfiguration
      // ****************************
      if (wr_arr && rec_to_array)
      begin
         s_d.row = s_q.row + 4'h1;
         s_d.full = s_q.full || (s_q.row == 4'hf);
         s_d.nv_cnt = 16'(`FLAC_PROG_CYCLES);
      end
      if (reconfig_req)
      begin
         s_d.rc_rej = busy && !s_q.nv_erase;
         s_d.rc_ack = !(busy && !s_q.nv_erase);
      end
      // Grant follows request once no store operation runs
      s_d.granted = s_q.unlocked && !busy;
      // ****************************
      // Command interpreter
      // ****************************
      if (s_q.tx_v && lnk.d_ready)
      begin
         s_d.tx_v = 1'b0;
      end
      if (lnk.h_valid && lnk.h_ready)
      begin
         if (lnk.h_start && !lnk.h_read)
         begin
            s_d.st = FLAC_OPC;
            s_d.argn = 2'h0;
         end
         else if (lnk.h_start && lnk.h_read)
         begin
            s_d.st = FLAC_RSP;
            s_d.rsp_stat = (s_q.opc == `FLAC_OP_UNLOCK);
            s_d.rd_byte = 3'h0;
            s_d.rd_vol = (s_q.opc == `FLAC_OP_READ_VOL);
            s_d.rd_row = (s_q.opc == `FLAC_OP_READ_REC) ? s_q.arg0[7:4] : 4'h0;
         end
         else if (s_q.st == FLAC_OPC)
         begin
            s_d.opc = lnk.h_data;
            s_d.st = FLAC_ARG;
            if (lnk.h_stop && lnk.h_data == `FLAC_OP_ERASE && s_q.prog && s_q.unlocked
                && s_q.granted && !s_q.ut_q2)
            begin
               s_d.st = FLAC_BUSY;
               s_d.nv_erase = 1'b1;
               s_d.granted = 1'b0;
               s_d.nv_cnt = 16'(`FLAC_ERASE_CYCLES);
            end
            else if (lnk.h_stop && lnk.h_data == `FLAC_OP_USER)
            begin
               s_d.prog = 1'b0;
               s_d.st = FLAC_IDLE;
            end
            else if (lnk.h_stop)
            begin
               s_d.st = FLAC_IDLE;
            end
         end
         else if (s_q.st == FLAC_ARG)
         begin
            s_d.argn = s_q.argn + 2'h1;
            if (s_q.argn == 2'h0)
            begin
               s_d.arg0 = lnk.h_data;
            end
            if (s_q.opc == `FLAC_OP_UNLOCK && s_q.argn == 2'h0 && !s_q.ut_q2)
            begin
               s_d.unlocked = (lnk.h_data == `FLAC_UNLOCK_KEY);
               s_d.granted = 1'b0;
            end
            if (s_q.opc == `FLAC_OP_PROG && s_q.argn == 2'h1
                && {s_q.arg0, lnk.h_data} == `FLAC_PROG_KEY)
            begin
               s_d.prog = !busy || s_q.nv_erase;
            end
            if (lnk.h_stop)
            begin
               s_d.st = FLAC_IDLE;
            end
         end
         if (lnk.h_stop && s_q.st == FLAC_RSP)
         begin
            s_d.st = FLAC_IDLE;
         end
      end
      if (s_q.st == FLAC_BUSY && !busy)
      begin
         s_d.st = FLAC_IDLE;
      end
      // ****************************
      // Read byte generation
      // ****************************
      if (s_q.st == FLAC_RSP && !s_q.tx_v && !lnk.h_nack)
      begin
         if (s_q.rsp_stat)
         begin
            s_d.tx = s_q.unlocked ? (`FLAC_STAT_REQ_BITS | (s_q.granted ? `FLAC_STAT_GNT_BITS : 8'h00))
                                  : (busy ? `FLAC_STAT_RECORDING : `FLAC_STAT_GNT_BITS);
            s_d.tx_v = 1'b1;
         end
         else if (s_q.granted && !s_q.ut_q2 && (s_q.rd_vol || s_q.opc == `FLAC_OP_READ_REC
                  || s_q.opc == `FLAC_OP_READ_ALL))
         begin
            s_d.tx = s_q.rd_vol ? pick(vol_q, s_q.rd_byte) : pick(arr[s_q.rd_row], s_q.rd_byte);
            s_d.tx_v = 1'b1;
            s_d.rd_byte = last ? 3'h0 : s_q.rd_byte + 3'h1;
            if (last && !s_q.rd_vol)
            begin
               s_d.rd_row = s_q.rd_row + 4'h1;
            end
         end
      end
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
         vol_q <= '0;
      end
      else
      begin
         s_q <= s_d;
         if (wr_arr && !rec_to_array)
         begin
            vol_q <= rec_data;
         end
      end
      if (wr_arr && rec_to_array)
      begin
         arr[s_q.row] <= rec_data;
      end
      else if (s_q.nv_erase && s_d.nv_cnt == '0)
      begin
         for (int i = 0; i < 16; i++)
         begin
            arr[i] <= '1;
         end
      end
   end
endmodule : flac_device

// >>> flac_fifo.sv
/*
 * Holds a synchronous valid/ready FIFO parameterised by width and depth.
 * Assumes one clock and a synchronous active-high reset.
 */
module flac_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } flac_fifo_s;
   logic [WIDTH-1:0] mem [DEPTH];
   flac_fifo_s s_q, s_d;
   logic push, pop;
   assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data = mem[s_q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop)
      begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
      if (push)
      begin
         mem[s_q.wp] <= in_data;
      end
   end
endmodule : flac_fifo

// >>> flac_host.sv
/*
 * Holds the host end: frames a command with arguments and collects read bytes into a FIFO.
 * Assumes the user drives one command at a time and drains read data from the FIFO port.
 */
`include "flac_defines.svh"
module flac_host
import flac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   flac_if.host lnk,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_opc,
   input wire logic [1:0] cmd_nargs,
   input wire logic [15:0] cmd_args,
   input wire logic [6:0] cmd_nread,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   output logic done
);
   typedef struct packed
   {
      flac_host_e st;
      logic [2:0] idx;
      logic [2:0] nbytes;
      logic [23:0] wbuf;
      logic [6:0] left;
      logic [6:0] nread;
      logic hv;
      logic [7:0] hd;
      logic hs;
      logic hr;
      logic hp;
      logic nack;
      logic dn;
      logic rdy;
   } flac_host_s;
   flac_host_s s_q, s_d;
   logic f_ready, f_valid;
   logic [7:0] f_data;
   flac_fifo #(.WIDTH(8), .DEPTH(`FLAC_FIFO_DEPTH)) flac_fifo_inst
   (
      .clk(clk),
      .rst(rst),
      .in_valid(lnk.d_valid && s_q.st == FLAC_H_RECV),
      .in_ready(f_ready),
      .in_data(lnk.d_data),
      .out_valid(f_valid),
      .out_ready(rd_ready),
      .out_data(f_data)
   );
   assign lnk.h_valid = s_q.hv;
   assign lnk.h_data = s_q.hd;
   assign lnk.h_start = s_q.hs;
   assign lnk.h_read = s_q.hr;
   assign lnk.h_stop = s_q.hp;
   assign lnk.h_nack = s_q.nack;
   // Back-pressure: read bytes are accepted only while the FIFO has room
   assign lnk.d_ready = f_ready && s_q.st == FLAC_H_RECV;
   assign cmd_ready = s_q.rdy;
   assign rd_valid = f_valid;
   assign rd_data = f_data;
   assign done = s_q.dn;
   always_comb
   begin
      s_d = s_q;
      s_d.dn = 1'b0;
      s_d.rdy = 1'b0;
      case (s_q.st)
         FLAC_H_IDLE:
         begin
            s_d.rdy = 1'b1;
            s_d.nack = 1'b0;
            if (cmd_valid && s_q.rdy)
            begin
               // Address byte with write bit, then opcode and arguments, stop if no read
               s_d.st = FLAC_H_SEND;
               s_d.rdy = 1'b0;
               s_d.wbuf = {cmd_opc, cmd_args};
               s_d.nbytes = 3'(cmd_nargs) + 3'h1;
               s_d.nread = cmd_nread;
               s_d.idx = 3'h0;
               s_d.hv = 1'b1;
               s_d.hs = 1'b1;
               s_d.hr = 1'b0;
               s_d.hp = 1'b0;
               s_d.hd = 8'h00;
            end
         end
         FLAC_H_SEND:
         begin
            if (s_q.hv && lnk.h_ready)
            begin
               s_d.hs = 1'b0;
               if (s_q.idx == s_q.nbytes && !s_q.hr)
               begin
                  s_d.hv = 1'b0;
                  s_d.hp = 1'b0;
                  s_d.st = (s_q.nread == '0) ? FLAC_H_DONE : FLAC_H_SEND;
                  if (s_q.nread != '0)
                  begin
                     // Repeated start with read bit
                     s_d.hv = 1'b1;
                     s_d.hs = 1'b1;
                     s_d.hr = 1'b1;
                  end
               end
               else if (s_q.hr)
               begin
                  s_d.hv = 1'b0;
                  s_d.st = FLAC_H_RECV;
                  s_d.left = s_q.nread;
               end
               else
               begin
                  s_d.idx = s_q.idx + 3'h1;
                  s_d.hd = s_q.wbuf[23:16];
                  s_d.wbuf = {s_q.wbuf[15:0], 8'h00};
                  s_d.hp = (s_q.idx + 3'h1 == s_q.nbytes) && (s_q.nread == '0);
               end
            end
         end
         FLAC_H_RECV:
         begin
            if (lnk.d_valid && lnk.d_ready)
            begin
               s_d.left = s_q.left - 7'h1;
               if (s_q.left == 7'h1)
               begin
                  // Last byte: NACK together with stop
                  s_d.nack = 1'b1;
                  s_d.hv = 1'b1;
                  s_d.hp = 1'b1;
                  s_d.hr = 1'b0;
                  s_d.st = FLAC_H_DONE;
               end
            end
         end
         FLAC_H_DONE:
         begin
            if (!s_q.hv || lnk.h_ready)
            begin
               s_d.hv = 1'b0;
               s_d.hp = 1'b0;
               s_d.dn = 1'b1;
               s_d.st = FLAC_H_IDLE;
            end
         end
         default:
         begin
            s_d.st = FLAC_H_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule : flac_host

// >>> flac_if.sv
/*
 * Holds the link joining host and device: a byte transaction channel standing for I2C framing.
 * Assumes both ends run on one clock; start, repeated start and stop are marked per byte.
 */
interface flac_if;
   // Host to device byte with framing marks
   logic h_valid;
   logic h_ready;
   logic [7:0] h_data;
   logic h_start;
   logic h_read;
   logic h_stop;
   // Device to host read byte; h_nack marks the last byte wanted
   logic d_valid;
   logic d_ready;
   logic [7:0] d_data;
   logic h_nack;
   modport dev
   (
      input h_valid, h_data, h_start, h_read, h_stop, d_ready, h_nack,
      output h_ready, d_valid, d_data
   );
   modport host
   (
      output h_valid, h_data, h_start, h_read, h_stop, d_ready, h_nack,
      input h_ready, d_valid, d_data
   );
endinterface : flac_if

// >>> flac_monitor.sv
/* Checker on the host-device link of the fault log access block.
   Assumes the flac_if signals, one clock and a synchronous active-high reset. */
`include "flac_defines.svh"
module flac_monitor
(
   input wire logic clk,
   input wire logic rst,
   input wire logic h_valid,
   input wire logic h_ready,
   input wire logic [7:0] h_data,
   input wire logic h_start,
   input wire logic h_read,
   input wire logic h_stop,
   input wire logic d_valid,
   input wire logic d_ready,
   input wire logic [7:0] d_data,
   input wire logic h_nack
);
   timeunit 1ns;
   timeprecision 1ps;
   // **************
   // Frame tracking
   // **************
   logic hx;
   logic opn_q;
   logic key_q;
   logic unl_q;
   logic [7:0] opc_q;
   logic [6:0] cnt_q;
   assign hx = h_valid && h_ready;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         opn_q <= 1'b0;
         key_q <= 1'b0;
         unl_q <= 1'b0;
         opc_q <= 8'h00;
         cnt_q <= 7'h00;
      end
      else if (hx)
      begin
         // Opcode follows a write start, the key follows the unlock opcode
         opn_q <= h_start && !h_read;
         key_q <= opn_q && h_data == `FLAC_OP_UNLOCK;
         if (opn_q)
            opc_q <= h_data;
         if (key_q)
            unl_q <= h_data == `FLAC_UNLOCK_KEY;
         if (h_start && h_read)
            cnt_q <= 7'h00;
      end
      else if (d_valid && d_ready)
         cnt_q <= cnt_q + 7'h01;
   end
   // ***************
   // Link properties
   // ***************
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_dev_byte_holds: assert property (
      d_valid && !d_ready |=> d_valid && $stable(d_data))
      else $error("device byte changed before taken");
   a_status_answer: assert property (
      hx && h_start && h_read && opc_q == `FLAC_OP_UNLOCK |-> ##[1:2] d_valid)
      else $error("no status byte after unlock read start");
   a_one_status_byte: assert property (
      d_valid && opc_q == `FLAC_OP_UNLOCK |-> cnt_q == 7'h00)
      else $error("more than one status byte");
   a_status_form: assert property (
      d_valid && opc_q == `FLAC_OP_UNLOCK |-> d_data inside {8'h00, 8'h30, 8'hc0, 8'hf0})
      else $error("status byte has an invalid pattern");
   a_wrong_key_clear: assert property (
      d_valid && opc_q == `FLAC_OP_UNLOCK && !unl_q |-> d_data[7:6] == 2'b00)
      else $error("request bits set after wrong key");
   a_right_key_req: assert property (
      d_valid && opc_q == `FLAC_OP_UNLOCK && unl_q |-> d_data[7:6] == 2'b11)
      else $error("request bits clear after right key");
   a_locked_silent: assert property (
      !unl_q && opc_q inside {`FLAC_OP_READ_VOL, `FLAC_OP_READ_REC, `FLAC_OP_READ_ALL}
      |-> !d_valid)
      else $error("log data sent while locked");
   a_erase_alone: assert property (
      hx && opn_q && h_data == `FLAC_OP_ERASE |-> h_stop)
      else $error("erase opcode not closing its frame");
   a_key_follows: assert property (
      hx && opn_q && h_data == `FLAC_OP_UNLOCK |-> !h_stop)
      else $error("unlock opcode sent without key");
   a_nack_stops: assert property (
      hx && h_nack |-> h_stop)
      else $error("not-acknowledge without stop");
endmodule : flac_monitor

// >>> flac_pkg.sv
/*
 * Holds the state types of the device end and of the host end of the fault log access block.
 * Assumes flac_defines.svh sits in the same folder.
 */
package flac_pkg;
   typedef logic [7:0] flac_byte_t;
   typedef enum logic [2:0]
   {
      FLAC_IDLE = 3'b000,
      FLAC_OPC = 3'b001,
      FLAC_ARG = 3'b011,
      FLAC_RSP = 3'b010,
      FLAC_BUSY = 3'b110
   } flac_dev_e;
   typedef enum logic [2:0]
   {
      FLAC_H_IDLE = 3'b000,
      FLAC_H_SEND = 3'b001,
      FLAC_H_RECV = 3'b011,
      FLAC_H_DONE = 3'b010
   } flac_host_e;
endpackage : flac_pkg
